// ==== design/pgasp_regs.vh ====
// What this block does
// [RL1] first byte of each word is instruction, second byte its operand
// [RL2] frame opens with chip select low; command applied when chip select rises
// [RL3] serial output always driven, forced low while chip select is high
// [RL4] both idle-low (0,0) and idle-high (1,1) clock modes accepted
// [RL5] input sampled on rising serial clock, output shifted on falling edge
// [RL6] in mode 0,0 chip select fall presents the first output bit
// [RL7] clock count not a multiple of 16 aborts the command
// [RL8] instruction, gain, channel registers are 8-bit write-only, no defaults; reset clears them to zero here
// [RL9] one chip select high-low-high cycle brings sequencer to known state
// [RL10] instruction: command in bits 7-5, register select in bit 0
// [RL11] 000 nop, 001 shutdown, 010 write, other codes act as nop
// [RL12] shutdown entered only after full word and chip select rise
// [RL13] write command leaves shutdown; repeated shutdown does not toggle
// [RL14] nop and shutdown ignore all other bits of the word
// [RL15] write goes to channel when select bit is one, else gain
// [RL16] gain code bits 2-0 select 1,2,4,5,8,10,16,32
// [RL17] compensation select changes together with the gain code
// [RL18] channel write updates input multiplexer on two-input variant
// [RL19] shutdown disables amplifier and floats its output
// [RL20] channel bit 0 picks second input; single-input variant always first
// [RL21] gain and channel retained through shutdown
// [RL22] shift register cleared on chip select rise so next 16 bits out are zero
// [RL23] aborted frame leaves gain, channel and shutdown unchanged
// [RL24] shift logic held cleared while chip select is high
`ifndef PGASP_REGS_VH
`define PGASP_REGS_VH
`define PGASP_WORD_BITS 16
`define PGASP_CMD_MSB 7
`define PGASP_CMD_LSB 5
`define PGASP_SEL_BIT 0
`define PGASP_CMD_NOP 3'h0
`define PGASP_CMD_SHDN 3'h1
`define PGASP_CMD_WRITE 3'h2
`define PGASP_GAIN_MSB 2
`define PGASP_CHAN_BIT 0
`define PGASP_COMP_LARGE 2'h0
`define PGASP_COMP_MEDIUM 2'h1
`define PGASP_COMP_SMALL 2'h2
`endif

// ==== design/pgasp_sync.v ====
`timescale 1ns/1ps
module pgasp_sync (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire d_in,
   output wire q_out
);
   reg s1_q;
   reg s2_q;
   // first stage read only by second stage
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
      end
   end
   assign q_out = s2_q;
endmodule

// ==== design/pgasp_spi_port.v ====
`timescale 1ns/1ps
`include "pgasp_regs.vh"
module pgasp_spi_port #(
   parameter TWO_INPUTS = 1
) (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire sck_in,
   input wire cs_n_in,
   input wire si_in,
   output reg so_out,
   output reg amp_enable_out,
   output reg amp_out_hiz_out,
   output reg [2:0] gain_code_out,
   output reg [1:0] comp_select_out,
   output reg input_channel_bit_out,
   output reg analog_input_second_out,
   output reg frame_abort_out
);
   ////////////////////////////////////////////////////////////////////////////
   wire sck_s;
   wire cs_n_s;
   wire si_s;
   reg sck_prev_q;
   reg cs_prev_q;
   reg [15:0] shift_q;
   reg [3:0] bit_cnt_q;
   reg any_clk_q;
   reg [7:0] instr_q;
   reg [7:0] gain_q;
   reg [7:0] chan_q;
   reg shdn_q;
   reg known_q;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire cs_rise;
   wire [15:0] word;
   wire [2:0] cmd;
   wire frame_ok;

   // pins cross from the serial domain through two flops each
   pgasp_sync u_sync_sck (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .d_in(sck_in), .q_out(sck_s));
   // cs idles high; reset value of its stage is low but a high pin shows after two edges
   pgasp_sync u_sync_cs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .d_in(cs_n_in), .q_out(cs_n_s));
   pgasp_sync u_sync_si (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .d_in(si_in), .q_out(si_s));

   // either idle level works: only edges inside a frame count
   assign sck_rise = sck_s & ~sck_prev_q; // RL4
   assign sck_fall = ~sck_s & sck_prev_q; // RL4
   assign cs_fall = ~cs_n_s & cs_prev_q;
   assign cs_rise = cs_n_s & ~cs_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // compensation band follows the gain code
   function [1:0] comp_of;
      input [2:0] g;
      begin
         if (g <= 3'h1) begin
            comp_of = `PGASP_COMP_LARGE;
         end else if (g <= 3'h5) begin
            comp_of = `PGASP_COMP_MEDIUM;
         end else begin
            comp_of = `PGASP_COMP_SMALL;
         end
      end
   endfunction

   // last sampled bit joins the word at the final rising edge of the serial clock
   assign word = shift_q;
   assign cmd = word[15-(7-`PGASP_CMD_MSB):13]; // RL1 RL10
   // whole words only: counter back at zero and at least one clock seen
   assign frame_ok = (bit_cnt_q == 4'h0) && any_clk_q && known_q; // RL7 RL9

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_prev_q <= 1'b0;
         // matches the sync stage reset level, so no false fall right after reset
         cs_prev_q <= 1'b0;
         shift_q <= 16'h0000;
         bit_cnt_q <= 4'h0;
         any_clk_q <= 1'b0;
         so_out <= 1'b0;
         known_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
         if (cs_n_s) begin
            // held cleared between frames
            shift_q <= 16'h0000; // RL22 RL24
            bit_cnt_q <= 4'h0; // RL24
            any_clk_q <= 1'b0;
            so_out <= 1'b0; // RL3
         end else begin
            if (cs_fall) begin
               known_q <= 1'b1; // RL9
               so_out <= shift_q[15]; // RL6
            end
            if (sck_rise) begin
               shift_q <= {shift_q[14:0], si_s}; // RL5
               bit_cnt_q <= bit_cnt_q + 4'h1;
               any_clk_q <= 1'b1;
            end else if (sck_fall && !cs_fall) begin
               so_out <= shift_q[15]; // RL5
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers have no power-up value in silicon; flops reset to zero here
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         instr_q <= 8'h00;
         gain_q <= 8'h00;
         chan_q <= 8'h00;
         shdn_q <= 1'b0;
         frame_abort_out <= 1'b0;
      end else begin
         frame_abort_out <= 1'b0;
         if (cs_rise && known_q) begin // RL2
            if (!frame_ok) begin
               frame_abort_out <= 1'b1; // RL7 RL23
            end else begin
               instr_q <= {word[15:13], 4'h0, word[8]}; // RL8 RL10
               case (cmd) // RL11
                  `PGASP_CMD_SHDN: begin
                     shdn_q <= 1'b1; // RL12 RL13 RL14
                  end
                  `PGASP_CMD_WRITE: begin
                     shdn_q <= 1'b0; // RL13 RL21
                     if (word[8]) begin
                        chan_q <= {7'h00, word[0]}; // RL15 RL20
                     end else begin
                        gain_q <= {5'h00, word[2:0]}; // RL15 RL16
                     end
                  end
                  default: begin
                     shdn_q <= shdn_q; // RL14
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         amp_enable_out <= 1'b0;
         amp_out_hiz_out <= 1'b1;
         gain_code_out <= 3'h0;
         comp_select_out <= `PGASP_COMP_LARGE;
         input_channel_bit_out <= 1'b0;
         analog_input_second_out <= 1'b0;
      end else begin
         amp_enable_out <= ~shdn_q; // RL19
         amp_out_hiz_out <= shdn_q; // RL19
         gain_code_out <= gain_q[`PGASP_GAIN_MSB:0]; // RL16
         comp_select_out <= comp_of(gain_q[`PGASP_GAIN_MSB:0]); // RL17
         input_channel_bit_out <= chan_q[`PGASP_CHAN_BIT];
         // single-input build always selects the first input
         analog_input_second_out <= (TWO_INPUTS != 0) & chan_q[`PGASP_CHAN_BIT]; // RL18 RL20
      end
   end
endmodule

// ==== bench/pgasp_chk.sv ====
`timescale 1ns/1ps
module pgasp_chk #(parameter TWO_INPUTS = 1) (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire cs_n_in,
   input wire so_out,
   input wire amp_enable_out,
   input wire amp_out_hiz_out,
   input wire [2:0] gain_code_out,
   input wire [1:0] comp_select_out,
   input wire input_channel_bit_out,
   input wire analog_input_second_out,
   input wire frame_abort_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_quiet;
      $stable(gain_code_out) && $stable(amp_enable_out) && $stable(input_channel_bit_out);
   endsequence
   property p_so_low; cs_n_in [*4] |-> !so_out; endproperty
   a_so_low: assert property (p_so_low) else $error("serial out not low");
   property p_comp; comp_select_out == (gain_code_out < 3'h2 ? 2'h0 : gain_code_out < 3'h6 ? 2'h1 : 2'h2);
   endproperty
   a_comp: assert property (p_comp) else $error("compensation mismatch");
   property p_hiz; amp_out_hiz_out == !amp_enable_out; endproperty
   a_hiz: assert property (p_hiz) else $error("float state wrong");
   property p_chan; analog_input_second_out == (TWO_INPUTS != 0 && input_channel_bit_out); endproperty
   a_chan: assert property (p_chan) else $error("input select wrong");
   // settings may only move once the frame has closed
   property p_apply; $changed(gain_code_out) || $changed(input_channel_bit_out) |-> $past(cs_n_in, 3); endproperty
   a_apply: assert property (p_apply) else $error("update inside frame");
   property p_pulse; frame_abort_out |=> !frame_abort_out; endproperty
   a_pulse: assert property (p_pulse) else $error("abort pulse too long");
   property p_quiet; frame_abort_out |=> s_quiet [*3]; endproperty
   a_quiet: assert property (p_quiet) else $error("abort changed settings");
   property p_shdn; $rose(amp_out_hiz_out) |-> $past(cs_n_in, 3); endproperty
   a_shdn: assert property (p_shdn) else $error("early shutdown");
   property p_wake; $rose(amp_enable_out) |-> $past(cs_n_in, 3); endproperty
   a_wake: assert property (p_wake) else $error("early wake");
endmodule
bind pgasp_spi_port pgasp_chk #(.TWO_INPUTS(TWO_INPUTS)) i_chk (.*);

// ==== bench/pgasp_host.sv ====
`timescale 1ns/1ps
module pgasp_host (
   input wire so_in,
   output reg sck_out = 1'b0,
   output reg cs_n_out = 1'b1,
   output reg si_out = 1'b0
);
   reg [31:0] rx = 32'h0;
   // clock only moves to the next idle level outside frames; out bit sampled just before each fall after a rise, long after it settled
   task xfer(input [31:0] w, input integer n, input integer m);
      integer i;
      begin
         sck_out = m != 0;
         #100 cs_n_out = 1'b0;
         for (i = n - 1; i >= 0; i = i - 1) begin
            #100 if (i != n - 1) rx = {rx[30:0], so_in};
            sck_out = 1'b0;
            si_out = w[i];
            #100 sck_out = 1'b1;
         end
         #100 rx = {rx[30:0], so_in};
         sck_out = m != 0;
         si_out = ~si_out;
         #100 cs_n_out = 1'b1;
      end
   endtask
endmodule

// ==== bench/pga_spi_command_port_tb.sv ====
`timescale 1ns/1ps
module pga_spi_command_port_tb;
   reg ref_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   wire sck, cs_n, si, so, en, hiz, ch, ch2, ab;
   wire [2:0] gain;
   wire [1:0] comp;
   integer num_errors = 0, num_checks = 0, num_aborts = 0, e_gain = 0, e_ch = 0, e_en = 1, i;
   reg [31:0] r;
   pgasp_host i_host (.so_in(so), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
   pgasp_spi_port i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
      .so_out(so), .amp_enable_out(en), .amp_out_hiz_out(hiz), .gain_code_out(gain), .comp_select_out(comp),
      .input_channel_bit_out(ch), .analog_input_second_out(ch2), .frame_abort_out(ab));
   initial forever #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (ab === 1'b1) num_aborts <= num_aborts + 1;
   ////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task frm(input [31:0] w, input integer n);
      begin
         @(posedge ref_clk_in) #1;
         i_host.xfer(w, n, $urandom % 2);
         repeat (12) @(posedge ref_clk_in);
         if (n % 16 == 0 && w[15:13] == 3'h1) e_en = 0;
         if (n % 16 == 0 && w[15:13] == 3'h2) begin
            e_en = 1;
            if (w[8]) e_ch = w[0]; else e_gain = w[2:0];
         end
         chk(gain, e_gain);
         chk(ch, e_ch);
         chk(en, e_en);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      r = $urandom(32'h294b);
      repeat (2) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      repeat (6) @(posedge ref_clk_in);
      frm(32'h0, 16);
      // unused instruction and data bits randomised, they must not matter
      for (i = 0; i < 10; i = i + 1) begin
         r = $urandom;
         if (i < 8) frm({16'h0, 3'h2, r[3:0], 1'b0, r[8:4], i[2:0]}, 16);
         else frm({16'h0, 3'h2, r[3:0], 1'b1, r[10:4], i[0]}, 16);
      end
      frm({16'h0, 3'h1, r[12:0]}, 16);
      frm({16'h0, 3'h1, r[13:1]}, 16);
      for (i = 0; i < 8; i = i + 1) if (i != 1 && i != 2) frm({16'h0, i[2:0], r[12:0]}, 16);
      frm(32'h4005, 16);
      frm(32'h4003, 15);
      frm(32'h14003, 17);
      chk(num_aborts, 2);
      frm(32'h40060000, 32);
      chk(i_host.rx, 32'h4006);
      frm(32'h00004006, 32);
      stop_test;
   end
   initial begin
      #500000;
      num_errors = num_errors + 1;
      stop_test;
   end
endmodule
